// ---- hdl/ledrx_consts.svh ----
// Purpose: shared constants of the led driver serial receive port
// Assumes: included by bare name from design files
// Notes:   guard and end counts are in edges of the double-rate clock; group and fifo counts are in words
`ifndef LEDRX_CONSTS_SVH
`define LEDRX_CONSTS_SVH

`define LEDRX_WORD_BITS      16
`define LEDRX_GUARD_EDGE     5'd16
`define LEDRX_GROUP_LAST     2'd3
`define LEDRX_END_ONES_LAST  5'd17
`define LEDRX_START_WORD     16'hffff
`define LEDRX_FIFO_DEPTH     32
`define LEDRX_TX_GAP_EDGES   18

`endif

// ---- hdl/ledrx_pkg.sv ----
// Purpose: types of the led driver serial receive port
// Assumes: nothing beyond the constants header
// Notes:   binary state codes are written out
package ledrx_pkg;

  // receive frame state
  typedef enum logic {
    RX_IDLE   = 1'b0,
    RX_ACTIVE = 1'b1
  } ledrx_rx_state_t;

  // transmit frame state
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } ledrx_tx_state_t;

endpackage : ledrx_pkg

// ---- hdl/ledrx_stream_if.sv ----
// Purpose: valid/ready word stream between port modules
// Assumes: one producer and one consumer on the same clock
// Notes:   a word moves when valid and ready are both high
`timescale 1ns/100ps
interface ledrx_stream_if #(
  parameter int WIDTH = 16
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ledrx_stream_if

// ---- hdl/ledrx_fifo.sv ----
// Purpose: receive push fifo, flip-flop storage
// Assumes: DEPTH is a power of two
// Notes:   ready falls when full, valid falls when empty
`timescale 1ns/100ps
module ledrx_fifo
  import ledrx_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  ledrx_stream_if.snk fill,
  ledrx_stream_if.src drain
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } ledrx_fifo_st_t;

  ledrx_fifo_st_t st_reg;
  ledrx_fifo_st_t st_next;
  logic           push;
  logic           pop;

  // handshakes; ready is honest so the pending word upstream stalls
  assign fill.ready  = (st_reg.cnt != FULL_CNT);
  assign drain.valid = (st_reg.cnt != '0);
  assign drain.data  = st_reg.mem[st_reg.rd];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = fill.data;
      st_next.wr             = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_next.cnt = st_reg.cnt + 1'b1;
      2'b01:   st_next.cnt = st_reg.cnt - 1'b1;
      default: st_next.cnt = st_reg.cnt;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_fifo_count_up: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    push && !pop |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1)
    else $error("fifo count did not rise on push");

endmodule : ledrx_fifo

// ---- hdl/ledrx_port.sv ----
// Purpose: serial receive port with frame transmitter for led drivers
// Assumes: link logic runs on falling edges of the double-rate clock
// Notes:   received words cross by toggle with data held 17 edges
`timescale 1ns/100ps
`include "ledrx_consts.svh"

// Functional notes
// - shift input bits on double clock falling
// - push each word; event every four words
// - idle to active on zero; back on end
// - group counter counts matches, wraps at four
// - frame end event only while active
// - zero detector forced low when disabled
// - wrong guard bit raises error event
// - edge counter held cleared while disabled
// - end counter match returns to idle
// - logic on double clock; bit clock out
// - edge mode selects bit clock source
// - clocks pass through transmit logic to pins
// - preamble all-ones word makes start bit
// - data line high after last word
// - serial output latched before the pin
// - enable bit gates reception, falling edge sample
module ledrx_port
  import ledrx_pkg::*;
#(
  parameter int FIFO_DEPTH = `LEDRX_FIFO_DEPTH
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        pwm_double_clock_i,
  input  wire logic        pwm_base_clock_i,
  input  wire logic        dual_edge_i,
  input  wire logic        rx_enable_i,
  input  wire logic        serial_data_in_i,
  input  wire logic [15:0] tx_word_i,
  input  wire logic        tx_last_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  output logic      [15:0] rx_word_o,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic             rx_active_o,
  output logic             group_event_o,
  output logic             check_err_o,
  output logic             frame_end_o,
  output logic             rx_overflow_o,
  output logic             serial_data_out_o,
  output logic             bit_clock_o,
  output logic             delayed_double_clock_o
);

  // link-domain state, clocked on falling double-rate edges
  typedef struct packed {
    logic [1:0]      en_sync;
    logic [1:0]      sin_sync;
    ledrx_rx_state_t rx_state;
    logic [4:0]      edge_cnt;
    logic [4:0]      end_cnt;
    logic [1:0]      grp_cnt;
    logic [15:0]     shift;
    logic [15:0]     word;
    logic            word_tgl;
    logic            grp_tgl;
    logic            err_tgl;
    logic            end_tgl;
    ledrx_tx_state_t tx_state;
    logic [15:0]     tx_shift;
    logic [4:0]      tx_cnt;
    logic            tx_guard;
    logic            tx_fin;
    logic            sout;
    logic [1:0]      req_sync;
    logic            req_seen;
    logic            ack_tgl;
  } ledrx_link_st_t;

  // system-domain state
  typedef struct packed {
    logic [3:0]  ev_s1;
    logic [3:0]  ev_s2;
    logic [3:0]  ev_prev;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_prev;
    logic        act_s1;
    logic        act_s2;
    logic        pend;
    logic [15:0] pend_word;
    logic        grp_irq;
    logic        err_irq;
    logic        end_irq;
    logic        ovf;
    logic        tx_full;
    logic        tx_rdy;
    logic        tx_req_tgl;
    logic [15:0] tx_buf_word;
    logic        tx_buf_last;
  } ledrx_sys_st_t;

  ledrx_link_st_t lr;
  ledrx_link_st_t ln;
  ledrx_sys_st_t  sr;
  ledrx_sys_st_t  sn;
  logic [1:0]     link_rst_s;
  logic           link_rst_b;
  logic           rx_en;
  logic           sin_s;
  logic           rx_active;
  logic           zero_bit_seen;
  logic           word_edge_match;
  logic           frame_end_match;
  logic           tx_avail;
  logic [3:0]     ev_edge;
  logic           ack_edge;

  ledrx_stream_if #(.WIDTH(`LEDRX_WORD_BITS)) fill_if ();
  ledrx_stream_if #(.WIDTH(`LEDRX_WORD_BITS)) drain_if ();

  // receive push fifo between capture and software
  ledrx_fifo #(
    .WIDTH (`LEDRX_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .fill      (fill_if),
    .drain     (drain_if)
  );

  assign fill_if.valid  = sr.pend;
  assign fill_if.data   = sr.pend_word;
  assign drain_if.ready = rx_ready_i;
  assign rx_word_o      = drain_if.data;
  assign rx_valid_o     = drain_if.valid;

  // clocks pass through here so clock and data share the same delay
  assign bit_clock_o = dual_edge_i ? pwm_base_clock_i
                                   : pwm_double_clock_i;
  assign delayed_double_clock_o = pwm_double_clock_i;

  // link reset: asserts at once, releases on a falling link edge
  always_ff @(negedge pwm_double_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_rst_s <= 2'h0;
    end else begin
      link_rst_s <= {link_rst_s[0], 1'b1};
    end
  end
  assign link_rst_b = link_rst_s[1];

  // decoded link conditions; enable, data in and tx request from second synchroniser stages
  assign rx_en           = lr.en_sync[1];
  assign sin_s           = lr.sin_sync[1];
  assign rx_active       = (lr.rx_state == RX_ACTIVE);
  assign zero_bit_seen   = rx_en & ~sin_s;
  assign word_edge_match = rx_active &
                           (lr.edge_cnt == `LEDRX_GUARD_EDGE);
  assign frame_end_match = rx_active & sin_s &
                           (lr.end_cnt == `LEDRX_END_ONES_LAST);
  assign tx_avail        = (lr.req_sync[1] != lr.req_seen);

  // link next state: receiver then transmitter
  always_comb begin
    ln          = lr;
    ln.en_sync  = {lr.en_sync[0], rx_enable_i};
    ln.sin_sync = {lr.sin_sync[0], serial_data_in_i};
    ln.req_sync = {lr.req_sync[0], sr.tx_req_tgl};
    if (!rx_en) begin
      ln.rx_state = RX_IDLE;
      ln.edge_cnt = 5'h0;
      ln.end_cnt  = 5'h0;
      ln.grp_cnt  = 2'h0;
    end else begin
      case (lr.rx_state)
        RX_IDLE: begin
          ln.edge_cnt = 5'h0;
          ln.end_cnt  = 5'h0;
          ln.grp_cnt  = 2'h0;
          if (zero_bit_seen) begin
            ln.rx_state = RX_ACTIVE;
          end
        end
        RX_ACTIVE: begin
          // run of ones marks the end; any zero restarts it
          ln.end_cnt = sin_s ? lr.end_cnt + 5'h1 : 5'h0;
          if (word_edge_match) begin
            ln.edge_cnt = 5'h0;
            ln.word     = lr.shift;
            ln.word_tgl = ~lr.word_tgl;
            if (sin_s == lr.shift[0]) begin
              ln.err_tgl = ~lr.err_tgl;
            end
            if (lr.grp_cnt == `LEDRX_GROUP_LAST) begin
              ln.grp_cnt = 2'h0;
              ln.grp_tgl = ~lr.grp_tgl;
            end else begin
              ln.grp_cnt = lr.grp_cnt + 2'h1;
            end
          end else begin
            ln.shift    = {lr.shift[14:0], sin_s};
            ln.edge_cnt = lr.edge_cnt + 5'h1;
          end
          if (frame_end_match) begin
            ln.rx_state = RX_IDLE;
            ln.end_tgl  = ~lr.end_tgl;
          end
        end
        default: begin
          ln.rx_state = RX_IDLE;
        end
      endcase
    end
    // transmitter: preamble word, then buffered words, guard each
    case (lr.tx_state)
      TX_IDLE: begin
        ln.sout = 1'b1;
        if (tx_avail) begin
          ln.tx_state = TX_SEND;
          ln.tx_shift = `LEDRX_START_WORD;
          ln.tx_cnt   = 5'h0;
          ln.tx_fin   = 1'b0;
        end
      end
      TX_SEND: begin
        if (lr.tx_cnt != `LEDRX_GUARD_EDGE) begin
          ln.sout     = lr.tx_shift[15];
          ln.tx_guard = ~lr.tx_shift[15];
          ln.tx_shift = {lr.tx_shift[14:0], 1'b0};
          ln.tx_cnt   = lr.tx_cnt + 5'h1;
        end else begin
          ln.sout   = lr.tx_guard;
          ln.tx_cnt = 5'h0;
          if (lr.tx_fin || !tx_avail) begin
            ln.tx_state = TX_IDLE;
          end else begin
            // buffer is frozen until the ack toggle comes back
            ln.tx_shift = sr.tx_buf_word;
            ln.tx_fin   = sr.tx_buf_last;
            ln.req_seen = lr.req_sync[1];
            ln.ack_tgl  = ~lr.ack_tgl;
          end
        end
      end
      default: begin
        ln.tx_state = TX_IDLE;
      end
    endcase
  end

  // link state register
  always_ff @(negedge pwm_double_clock_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  assign ev_edge  = sr.ev_s2 ^ sr.ev_prev;
  assign ack_edge = sr.ack_s2 ^ sr.ack_prev;

  // system next state: event pulses, word capture, tx buffer
  always_comb begin
    sn         = sr;
    sn.ev_s1   = {lr.end_tgl, lr.err_tgl, lr.grp_tgl, lr.word_tgl};
    sn.ev_s2   = sr.ev_s1;
    sn.ev_prev = sr.ev_s2;
    sn.ack_s1  = lr.ack_tgl;
    sn.ack_s2  = sr.ack_s1;
    sn.ack_prev = sr.ack_s2;
    sn.act_s1  = lr.rx_state;
    sn.act_s2  = sr.act_s1;
    sn.grp_irq = ev_edge[1];
    sn.err_irq = ev_edge[2];
    sn.end_irq = ev_edge[3];
    // a full fifo stalls the pending word; a newer one replaces it
    sn.ovf = ev_edge[0] & sr.pend & ~fill_if.ready;
    if (sr.pend && fill_if.ready) begin
      sn.pend = 1'b0;
    end
    if (ev_edge[0]) begin
      sn.pend      = 1'b1;
      sn.pend_word = lr.word;
    end
    if (ack_edge) begin
      sn.tx_full = 1'b0;
    end
    if (tx_valid_i && !sr.tx_full) begin
      sn.tx_full     = 1'b1;
      sn.tx_buf_word = tx_word_i;
      sn.tx_buf_last = tx_last_i;
      sn.tx_req_tgl  = ~sr.tx_req_tgl;
    end
    sn.tx_rdy = ~sn.tx_full;
  end

  // system state register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sr <= '0;
    end else begin
      sr <= sn;
    end
  end

  assign tx_ready_o        = sr.tx_rdy;
  assign rx_active_o       = sr.act_s2;
  assign group_event_o     = sr.grp_irq;
  assign check_err_o       = sr.err_irq;
  assign frame_end_o       = sr.end_irq;
  assign rx_overflow_o     = sr.ovf;
  assign serial_data_out_o = lr.sout;

  chk_disable_clears_cnt: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    !rx_en |=> lr.edge_cnt == 5'h0 && lr.rx_state == RX_IDLE)
    else $error("edge counter not held while disabled");
  chk_zero_forced_low: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    !rx_en && !rx_active && !sin_s |=> !rx_active)
    else $error("zero bit started a frame while disabled");
  chk_start_enters_act: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    !rx_active && zero_bit_seen |=> rx_active && lr.edge_cnt == 5'h0)
    else $error("zero bit did not start a frame");
  chk_end_to_idle: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    rx_active && sin_s && lr.end_cnt == `LEDRX_END_ONES_LAST |=> !rx_active)
    else $error("eighteen ones did not end the frame");
  chk_group_wraps: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    word_edge_match && lr.grp_cnt == 2'h3 && rx_en
    |=> lr.grp_cnt == 2'h0 && lr.grp_tgl != $past(lr.grp_tgl))
    else $error("group counter did not wrap at four words");
  chk_end_gated_act: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    $changed(lr.end_tgl) |-> $past(rx_active))
    else $error("frame end event outside active state");
  chk_guard_error: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    word_edge_match && rx_en && sin_s == lr.shift[0]
    |=> lr.err_tgl != $past(lr.err_tgl))
    else $error("bad guard bit not reported");
  chk_shift_sample: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    rx_en && rx_active && !word_edge_match |=> lr.shift[0] == $past(sin_s)
    && lr.edge_cnt == $past(lr.edge_cnt) + 5'h1)
    else $error("input bit not shifted in");
  // the edge that releases link reset still loads zeros, so skip it
  chk_tx_idle_high: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    lr.tx_state == TX_IDLE ##1 (lr.tx_state == TX_IDLE && $past(link_rst_b))
    |-> lr.sout)
    else $error("data line not high after frame");
  chk_tx_preamble: assert property (
    @(negedge pwm_double_clock_i) disable iff (!link_rst_b)
    lr.tx_state == TX_IDLE && tx_avail
    |=> lr.tx_shift == 16'hffff ##17 !lr.sout)
    else $error("start bit not produced after preamble");
  chk_word_pushed: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    ev_edge[0] |=> sr.pend && sr.pend_word == $past(lr.word))
    else $error("received word not queued for the fifo");

endmodule : ledrx_port

// ---- testbench/ledrx_driver_model.sv ----
// Purpose: model of the led driver chain at the far end of the port
// Assumes: the port samples our line on falling double-clock edges
// Notes:   idle line is high; frames from the port are decoded here
`timescale 1ns/100ps
module ledrx_driver_model (
  input  wire logic        link_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sdo_i,
  output logic             sdi_o,
  output logic      [15:0] got_word_o,
  output logic             got_guard_ok_o,
  output logic             got_stb_o
);
  logic [16:0] sh_reg;
  logic        seen1;
  int          k;

  initial begin
    sdi_o = 1'b1;
    got_stb_o = 1'b0;
    got_word_o = 16'h0000;
    got_guard_ok_o = 1'b0;
    seen1 = 1'b0;
  end

  // one frame: start zero, words msb first with guard, then a long high run
  task automatic send_frame(input logic [15:0] w[$], input int bad);
    @(posedge link_clk_i) sdi_o <= 1'b0;
    foreach (w[i]) begin
      for (int b = 15; b >= 0; b--) begin
        @(posedge link_clk_i) sdi_o <= w[i][b];
      end
      @(posedge link_clk_i) sdi_o <= ~w[i][0] ^ (i == bad);
    end
    repeat (20) @(posedge link_clk_i) sdi_o <= 1'b1;
  endtask : send_frame

  // decode at mid-bit; the port moves its line on falling edges
  always begin
    got_stb_o <= 1'b0;
    @(posedge link_clk_i);
    // the line reads low in reset, so wait for a high first
    seen1 = rst_b_i && (seen1 || sdo_i === 1'b1);
    if (seen1 && sdo_i === 1'b0) begin
      do begin
        for (k = 0; k < 17; k++) begin
          @(posedge link_clk_i);
          got_stb_o <= 1'b0;
          sh_reg = {sh_reg[15:0], sdo_i};
        end
        if (sh_reg !== 17'h1ffff) begin
          got_word_o     <= sh_reg[16:1];
          got_guard_ok_o <= (sh_reg[0] === ~sh_reg[1]);
          got_stb_o      <= 1'b1;
        end
      end while (sh_reg !== 17'h1ffff);
    end
  end
endmodule : ledrx_driver_model

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench of the led driver serial receive port
// Assumes: fifo shrunk to four words so the full case comes quickly
// Notes:   expected words are queued by run_rx and send_tx, popped by monitors
`timescale 1ns/100ps
module testbench;
  localparam int DEPTH = 4;
  logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, pwm_double_clock_i = 1'b0;
  logic        pwm_base_clock_i = 1'b0, dual_edge_i = 1'b0, rx_enable_i = 1'b1;
  logic        serial_data_in_i, tx_last_i = 1'b0, tx_valid_i = 1'b0;
  logic        rx_ready_i = 1'b0, hold = 1'b0, got_ok, got_stb, exp_clk;
  logic [15:0] tx_word_i = 16'h0000, rx_word_o, got_word, e_rx, e_tx;
  logic        tx_ready_o, rx_valid_o, rx_active_o, group_event_o, check_err_o;
  logic        frame_end_o, rx_overflow_o, serial_data_out_o, bit_clock_o;
  logic        delayed_double_clock_o;
  logic [31:0] lfsr = 32'hd8da, wseed = 32'hd8da;
  logic [15:0] exp_q[$], tx_q[$];
  int          n_fail = 0, cmp_count = 0;
  int          ev[4];

  ledrx_port #(.FIFO_DEPTH(DEPTH)) i_dut (
    .clk_sys_i, .rst_b_i, .pwm_double_clock_i, .pwm_base_clock_i,
    .dual_edge_i, .rx_enable_i, .serial_data_in_i, .tx_word_i, .tx_last_i,
    .tx_valid_i, .tx_ready_o, .rx_word_o, .rx_valid_o, .rx_ready_i,
    .rx_active_o, .group_event_o, .check_err_o, .frame_end_o,
    .rx_overflow_o, .serial_data_out_o, .bit_clock_o, .delayed_double_clock_o
  );

  ledrx_driver_model i_led (
    .link_clk_i(pwm_double_clock_i), .rst_b_i, .sdo_i(serial_data_out_o),
    .sdi_o(serial_data_in_i), .got_word_o(got_word), .got_guard_ok_o(got_ok),
    .got_stb_o(got_stb)
  );

  // link clock offset so its edges never meet the system clock's
  always #5 clk_sys_i = ~clk_sys_i;
  initial #1.3 forever #3 pwm_double_clock_i = ~pwm_double_clock_i;
  always @(posedge pwm_double_clock_i) pwm_base_clock_i <= ~pwm_base_clock_i;

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // random drain stalls, held off entirely while the fifo fills
  always @(negedge clk_sys_i) begin
    lfsr = lfsr_step(lfsr);
    rx_ready_i <= !hold && lfsr[3];
  end

  // fifo drain monitor and event pulse counters
  always @(posedge clk_sys_i) begin
    if (rst_b_i && rx_valid_o === 1'b1 && rx_ready_i) begin
      e_rx = (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_word_o;
      chk_word(rx_word_o, e_rx);
    end
    if (rst_b_i) begin
      ev[0] += (group_event_o === 1'b1);
      ev[1] += (check_err_o === 1'b1);
      ev[2] += (frame_end_o === 1'b1);
      ev[3] += (rx_overflow_o === 1'b1);
    end
  end

  // words decoded by the far end against the queue of sent words
  always @(posedge pwm_double_clock_i) begin
    if (got_stb === 1'b1) begin
      e_tx = (tx_q.size() > 0) ? tx_q.pop_front() : ~got_word;
      chk_word(got_word, e_tx);
      chk_val(got_ok, 1);
    end
  end

  // bounded wait for a queue to empty, then a quiet spell
  task automatic wait_q(input bit tx);
    int t;
    t = 0;
    while ((tx ? tx_q.size() : exp_q.size()) > 0 && t < 5000) begin
      @(negedge clk_sys_i);
      t++;
    end
    repeat (30) @(negedge clk_sys_i);
    if (t >= 5000) begin
      n_fail++;
      results();
    end
  endtask : wait_q

  // valid stays up between words; the caller drops it after the last
  task automatic send_tx(input logic [15:0] w, input logic last);
    int t;
    t = 0;
    tx_word_i <= w;
    tx_last_i <= last;
    tx_valid_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (tx_ready_o !== 1'b1 && t < 2000);
    tx_q.push_back(w);
    @(negedge clk_sys_i);
    if (t >= 2000) begin
      n_fail++;
      results();
    end
  endtask : send_tx

  // one received frame; full holds the drain off, en low disables
  task automatic run_rx(input string nm, input int n, input int bad,
                        input logic en, input logic full);
    logic [15:0] w[$];
    int          keep;
    w = {};
    keep = full ? DEPTH : n;
    ev = '{default: 0};
    rx_enable_i <= en;
    hold <= full;
    repeat (10) @(negedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      wseed = lfsr_step(wseed);
      w.push_back(wseed[15:0]);
      if (en && i < keep) exp_q.push_back(wseed[15:0]);
    end
    // end run arrives as one more word of ones
    if (en) exp_q.push_back(16'hffff);
    fork
      i_led.send_frame(w, bad);
      begin
        repeat (40) @(negedge clk_sys_i);
        chk_val(rx_active_o, en);
      end
    join
    repeat (20) @(negedge clk_sys_i);
    hold <= 1'b0;
    wait_q(1'b0);
    chk_val(ev[0], en ? (n + 1) / 4 : 0);
    chk_val(ev[1], en ? (bad < n) + 1 : 0);
    chk_val(ev[2], en);
    chk_val(ev[3], (en && full) ? n - DEPTH : 0);
    chk_val(rx_active_o, 0);
    $display("test %s done", nm);
  endtask : run_rx

  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys_i);
    chk_val(rx_active_o, 0);
    chk_val(group_event_o, 0);
    chk_val(rx_valid_o, 0);
    rst_b_i <= 1'b1;
    repeat (10) @(negedge clk_sys_i);
    for (int m = 0; m < 2; m++) begin
      dual_edge_i <= m[0];
      repeat (8) begin
        @(negedge clk_sys_i);
        #1;
        exp_clk = m ? pwm_base_clock_i : pwm_double_clock_i;
        chk_val(bit_clock_o, exp_clk);
        chk_val(delayed_double_clock_o, pwm_double_clock_i);
      end
    end
    $display("test clocks done");
    run_rx("rx_plain", 4, 99, 1'b1, 1'b0);
    run_rx("rx_guard", 8, 2, 1'b1, 1'b0);
    run_rx("rx_full", 8, 99, 1'b1, 1'b1);
    run_rx("rx_off", 4, 1, 1'b0, 1'b0);
    wseed = lfsr_step(wseed);
    send_tx(16'h5555, 1'b0);
    send_tx(wseed[15:0], 1'b1);
    tx_valid_i <= 1'b0;
    wait_q(1'b1);
    chk_val(serial_data_out_o, 1);
    send_tx(16'h0001, 1'b1);
    tx_valid_i <= 1'b0;
    wait_q(1'b1);
    chk_val(serial_data_out_o, 1);
    $display("test tx done");
    results();
  end
endmodule : testbench
